// File: inc/dw_store_pkg.sv
// Shared constants and carrier types for the doubleword store unit
package dw_store_pkg;
    localparam int XLEN = 64;
    localparam int PA_W = 40;
    localparam int REG_W = 5;
    // Monitored block: one 64-byte line, sized to the largest cache line
    localparam int BLOCK_LSB = 6;
    localparam int OPC_LSB = 26;
    localparam int BASE_LSB = 21;
    localparam int SRC_LSB = 16;
    localparam int OFS_W = 16;
    localparam int ALIGN_BITS = 3;
    localparam int UNIT_LSB = 26;
    localparam logic [5:0] OPC_COND_STORE = 6'h3C;
    localparam logic [5:0] OPC_PLAIN_STORE = 6'h3F;
    localparam logic [3:0] OPC_COPRO_PREFIX = 4'hF;
    localparam logic LINK_FLAG_RESET = 1'h0;
    localparam logic [XLEN-1:0] SUCCESS_VALUE = 64'h0000000000000001;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_TLB_REFILL = 3'h1,
        EXC_TLB_INVALID = 3'h2,
        EXC_TLB_MODIFIED = 3'h3,
        EXC_ADDR_ERROR = 3'h4,
        EXC_RESERVED = 3'h5,
        EXC_COP_UNUSABLE = 3'h6
    } exc_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_COPRO = 5'h02,
        ST_XLATE = 5'h04,
        ST_WRITE = 5'h08,
        ST_FINISH = 5'h10
    } state_t;

    typedef struct packed {
        logic [31:0] instr;
        logic [XLEN-1:0] base_val;
        logic [XLEN-1:0] src_val;
    } issue_t;

    typedef struct packed {
        logic valid;
        logic [PA_W-1:0] paddr;
    } addr_evt_t;

    typedef struct packed {
        logic valid;
        logic [PA_W-1:0] paddr;
        logic refill;
        logic invalid;
        logic modified;
    } xlate_rsp_t;

    typedef struct packed {
        logic [PA_W-1:0] paddr;
        logic [XLEN-1:0] data;
    } mem_req_t;

    typedef struct packed {
        logic [REG_W-1:0] dest;
        logic [XLEN-1:0] value;
    } wb_t;

    typedef struct packed {
        logic [1:0] unit;
        logic [REG_W-1:0] src;
    } copro_req_t;
endpackage

// File: src/dw_store_unit.sv
// Execution of the conditional, plain and coprocessor doubleword stores
//
// Behaviour
// RULE1 - Conditional store: opcode 111100, base 25:21, source 20:16, offset 15:0.
// RULE2 - Effective address is sign-extended 16-bit offset plus base register.
// RULE3 - Conditional success writes all 64 source bits, then returns one.
// RULE4 - Flag clear: no write, returns zero; result is 63 zeros and flag.
// RULE5 - Coherent store by another agent into monitored block forces failure.
// RULE6 - Exception taken or exception return between the pair forces failure.
// RULE7 - Other accesses or a wide code span may give either outcome.
// RULE8 - Software pairs linked load and conditional store on one address.
// RULE9 - Target must be cached; coherent accesses needed for multiprocessor atomicity.
// RULE10 - Uniprocessor atomicity needs one consistent cached access type.
// RULE11 - Conditional store misaligned in low three bits: address error, no write.
// RULE12 - Software keeps low three offset bits zero for these stores.
// RULE13 - Conditional store reports TLB, address and reserved errors, never bus error.
// RULE14 - Plain store, opcode 111111, writes all 64 bits after translation.
// RULE15 - Plain and coprocessor stores misaligned: address error instead of write.
// RULE16 - Coprocessor store 1111zz stores 64 bits supplied by coprocessor zz.
// RULE17 - Coprocessor store with usable bit clear raises coprocessor unusable.
// RULE18 - Units 0 to 3; unit 0 opcode belongs to another instruction. Here unit 3 (opcode 111111) also decodes as the plain store.
// RULE19 - Software never enables an unimplemented coprocessor.
// RULE20 - Monitored block is sized to the largest cache line.
// RULE21 - One link flag: linked load sets, failure events clear, store samples.
`timescale 1ns/1ns
module dw_store_unit (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire dw_store_pkg::issue_t issue,
    output logic issue_ready,
    input wire logic enable64,
    input wire logic [3:0] copro_usable,
    input wire dw_store_pkg::addr_evt_t linked_double_load,
    input wire dw_store_pkg::addr_evt_t coherent_store,
    input wire logic exc_taken,
    input wire logic exception_return_op,
    output logic copro_req_valid,
    output dw_store_pkg::copro_req_t copro_req,
    input wire logic copro_rsp_valid,
    input wire logic [63:0] copro_store_data,
    output logic xlate_req_valid,
    output logic [63:0] xlate_vaddr,
    input wire dw_store_pkg::xlate_rsp_t xlate_rsp,
    output logic mem_req_valid,
    output dw_store_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    output logic wb_valid,
    output dw_store_pkg::wb_t wb,
    output logic done,
    output dw_store_pkg::exc_t exc,
    output logic link_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the issued word

    logic [5:0] opc;
    logic [63:0] ea;
    logic is_cond;
    logic is_plain;
    logic is_copro;
    logic [1:0] unit;

    assign opc = issue.instr[dw_store_pkg::OPC_LSB +: 6];
    assign unit = issue.instr[dw_store_pkg::UNIT_LSB +: 2];
    assign is_cond = (opc == dw_store_pkg::OPC_COND_STORE); // RULE1
    assign is_plain = (opc == dw_store_pkg::OPC_PLAIN_STORE); // RULE14
    // Zero and three are the other two stores, so unit 0 never reaches here
    assign is_copro = (opc[5:2] == dw_store_pkg::OPC_COPRO_PREFIX)
        && !is_cond && !is_plain; // RULE18
    assign ea = {{(64 - dw_store_pkg::OFS_W){issue.instr[dw_store_pkg::OFS_W-1]}},
        issue.instr[dw_store_pkg::OFS_W-1:0]} + issue.base_val; // RULE2

    ////////////////////////////////////////////////////////////////////////////
    // State

    dw_store_pkg::state_t state;
    dw_store_pkg::state_t next_state;
    logic cond_op;
    logic next_cond_op;
    logic [4:0] dest;
    logic [4:0] next_dest;
    logic [63:0] store_data;
    logic [63:0] next_store_data;
    logic [39:0] link_addr;
    logic [39:0] next_link_addr;
    logic next_link_flag;
    logic next_issue_ready;
    logic next_copro_req_valid;
    dw_store_pkg::copro_req_t next_copro_req;
    logic next_xlate_req_valid;
    logic [63:0] next_xlate_vaddr;
    logic next_mem_req_valid;
    dw_store_pkg::mem_req_t next_mem_req;
    logic next_wb_valid;
    dw_store_pkg::wb_t next_wb;
    logic next_done;
    dw_store_pkg::exc_t next_exc;
    logic snoop_hit;
    logic flag_clear;

    // Block match ignores offset bits within the monitored line
    assign snoop_hit = coherent_store.valid && (coherent_store.paddr[39:dw_store_pkg::BLOCK_LSB]
        == link_addr[39:dw_store_pkg::BLOCK_LSB]); // RULE5 RULE20
    // Both the taking of an exception and the return from one clear the flag
    assign flag_clear = snoop_hit || exc_taken || exception_return_op; // RULE6

    always_comb begin
        next_state = state;
        next_cond_op = cond_op;
        next_dest = dest;
        next_store_data = store_data;
        next_link_addr = link_addr;
        next_link_flag = link_flag;
        next_issue_ready = 1'h0;
        next_copro_req_valid = 1'h0;
        next_copro_req = copro_req;
        next_xlate_req_valid = 1'h0;
        next_xlate_vaddr = xlate_vaddr;
        next_mem_req_valid = mem_req_valid;
        next_mem_req = mem_req;
        next_wb_valid = 1'h0;
        next_wb = wb;
        next_done = 1'h0;
        next_exc = exc;

        // Other accesses between the pair leave the flag untouched
        if (flag_clear) begin
            next_link_flag = 1'h0; // RULE7
        end
        // A new linked load wins over a clear arriving in the same cycle
        if (linked_double_load.valid) begin
            next_link_flag = 1'h1; // RULE21
            next_link_addr = linked_double_load.paddr;
        end

        case (state)
            dw_store_pkg::ST_IDLE: begin
                next_issue_ready = 1'h1;
                // Ready is low on the first idle cycle after reset, so no early take
                if (issue_valid && issue_ready) begin
                    next_issue_ready = 1'h0;
                    next_cond_op = is_cond;
                    next_dest = issue.instr[dw_store_pkg::SRC_LSB +: 5];
                    next_store_data = issue.src_val; // RULE3 RULE14
                    next_xlate_vaddr = ea;
                    next_state = dw_store_pkg::ST_FINISH;
                    if (!enable64 || !(is_cond || is_plain || is_copro)) begin
                        next_exc = dw_store_pkg::EXC_RESERVED;
                    end else if (is_copro && !copro_usable[unit]) begin
                        next_exc = dw_store_pkg::EXC_COP_UNUSABLE; // RULE17
                    end else if (ea[dw_store_pkg::ALIGN_BITS-1:0] != 3'h0) begin
                        // Checked before translation, so no memory traffic
                        next_exc = dw_store_pkg::EXC_ADDR_ERROR; // RULE11 RULE15
                    end else if (is_copro) begin
                        next_exc = dw_store_pkg::EXC_NONE;
                        next_copro_req_valid = 1'h1; // RULE16
                        next_copro_req.unit = unit;
                        next_copro_req.src = issue.instr[dw_store_pkg::SRC_LSB +: 5];
                        next_state = dw_store_pkg::ST_COPRO;
                    end else begin
                        next_exc = dw_store_pkg::EXC_NONE;
                        next_xlate_req_valid = 1'h1;
                        next_state = dw_store_pkg::ST_XLATE;
                    end
                end
            end
            dw_store_pkg::ST_COPRO: begin
                if (copro_rsp_valid) begin
                    next_store_data = copro_store_data; // RULE16
                    next_xlate_req_valid = 1'h1;
                    next_state = dw_store_pkg::ST_XLATE;
                end
            end
            dw_store_pkg::ST_XLATE: begin
                if (xlate_rsp.valid) begin
                    next_state = dw_store_pkg::ST_FINISH;
                    // Only translation faults are reported here, never a bus error
                    if (xlate_rsp.refill) begin
                        next_exc = dw_store_pkg::EXC_TLB_REFILL; // RULE13
                    end else if (xlate_rsp.invalid) begin
                        next_exc = dw_store_pkg::EXC_TLB_INVALID; // RULE13
                    end else if (xlate_rsp.modified) begin
                        next_exc = dw_store_pkg::EXC_TLB_MODIFIED; // RULE13
                    end else if (cond_op && !link_flag) begin
                        // Failed attempt: no write, zero result
                        next_wb_valid = 1'h1; // RULE4
                        next_wb.dest = dest;
                        next_wb.value = {63'h0, link_flag}; // RULE4
                    end else begin
                        next_mem_req_valid = 1'h1; // RULE3 RULE14
                        next_mem_req.paddr = xlate_rsp.paddr;
                        next_mem_req.data = store_data;
                        next_state = dw_store_pkg::ST_WRITE;
                    end
                end
            end
            dw_store_pkg::ST_WRITE: begin
                if (mem_ack) begin
                    next_mem_req_valid = 1'h0;
                    next_state = dw_store_pkg::ST_FINISH;
                    if (cond_op) begin
                        next_wb_valid = 1'h1;
                        next_wb.dest = dest;
                        next_wb.value = dw_store_pkg::SUCCESS_VALUE; // RULE3
                        // The flag is spent by a completed sequence
                        next_link_flag = linked_double_load.valid; // RULE21
                    end
                end
            end
            dw_store_pkg::ST_FINISH: begin
                next_done = 1'h1;
                next_issue_ready = 1'h1;
                next_state = dw_store_pkg::ST_IDLE;
            end
            default: begin
                next_state = dw_store_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= dw_store_pkg::ST_IDLE;
            cond_op <= 1'h0;
            dest <= 5'h00;
            store_data <= 64'h0000000000000000;
            link_addr <= 40'h0000000000;
            link_flag <= dw_store_pkg::LINK_FLAG_RESET;
            issue_ready <= 1'h0;
            copro_req_valid <= 1'h0;
            copro_req <= '0;
            xlate_req_valid <= 1'h0;
            xlate_vaddr <= 64'h0000000000000000;
            mem_req_valid <= 1'h0;
            mem_req <= '0;
            wb_valid <= 1'h0;
            wb <= '0;
            done <= 1'h0;
            exc <= dw_store_pkg::EXC_NONE;
        end else begin
            state <= next_state;
            cond_op <= next_cond_op;
            dest <= next_dest;
            store_data <= next_store_data;
            link_addr <= next_link_addr;
            link_flag <= next_link_flag;
            issue_ready <= next_issue_ready;
            copro_req_valid <= next_copro_req_valid;
            copro_req <= next_copro_req;
            xlate_req_valid <= next_xlate_req_valid;
            xlate_vaddr <= next_xlate_vaddr;
            mem_req_valid <= next_mem_req_valid;
            mem_req <= next_mem_req;
            wb_valid <= next_wb_valid;
            wb <= next_wb;
            done <= next_done;
            exc <= next_exc;
        end
    end

endmodule

// File: testbench/dw_store_assertions.sv
// Port-level checker for the doubleword store unit
`timescale 1ns/1ns
module dw_store_checker (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issue_valid,
    input wire dw_store_pkg::issue_t issue,
    input wire logic issue_ready,
    input wire logic enable64,
    input wire logic [3:0] copro_usable,
    input wire dw_store_pkg::addr_evt_t linked_double_load,
    input wire dw_store_pkg::addr_evt_t coherent_store,
    input wire logic exc_taken,
    input wire logic exception_return_op,
    input wire logic copro_req_valid,
    input wire dw_store_pkg::copro_req_t copro_req,
    input wire logic xlate_req_valid,
    input wire logic [63:0] xlate_vaddr,
    input wire dw_store_pkg::xlate_rsp_t xlate_rsp,
    input wire logic mem_req_valid,
    input wire dw_store_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic wb_valid,
    input wire dw_store_pkg::wb_t wb,
    input wire logic done,
    input wire dw_store_pkg::exc_t exc,
    input wire logic link_flag
);
    wire logic take = issue_valid && issue_ready;
    wire logic [5:0] op = issue.instr[31:26];
    wire logic [63:0] ea = issue.base_val + {{48{issue.instr[15]}}, issue.instr[15:0]};
    wire logic cop = op[5:2] == dw_store_pkg::OPC_COPRO_PREFIX && (op[1] ^ op[0]);
    wire logic bad = xlate_rsp.refill || xlate_rsp.invalid || xlate_rsp.modified;
    logic [5:0] op_q;
    wire logic cond = op_q == dw_store_pkg::OPC_COND_STORE;
    logic [39:0] blk;
    // Opcode kept per instruction, block kept per linked load
    always_ff @(posedge core_clk) begin
        if (take) begin
            op_q <= op;
        end
        if (linked_double_load.valid) begin
            blk <= linked_double_load.paddr >> dw_store_pkg::BLOCK_LSB;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    addr_form_a: assert property (
        take && enable64 && op == dw_store_pkg::OPC_PLAIN_STORE && ea[2:0] == 3'h0
        |=> xlate_req_valid && xlate_vaddr == $past(ea)) else $error("bad address");
    misalign_error_a: assert property (
        take && enable64 && op[5:1] == 5'h1E && ea[2:0] != 3'h0 |=> !xlate_req_valid
        ##1 done && exc == dw_store_pkg::EXC_ADDR_ERROR) else $error("no address error");
    reserved_op_a: assert property (
        take && !enable64 |=> !xlate_req_valid ##1 done && exc == dw_store_pkg::EXC_RESERVED)
        else $error("no reserved error");
    copro_unusable_a: assert property (
        take && enable64 && cop && !copro_usable[op[1:0]] |=> !copro_req_valid
        ##1 done && exc == dw_store_pkg::EXC_COP_UNUSABLE) else $error("no unusable error");
    copro_fetch_a: assert property (
        take && enable64 && cop && copro_usable[op[1:0]] && ea[2:0] == 3'h0 |=> copro_req_valid
        && copro_req == {$past(op[1:0]), $past(issue.instr[20:16])}) else $error("bad fetch");
    cond_fail_a: assert property (
        xlate_rsp.valid && !bad && cond && !link_flag
        |=> wb_valid && wb.value == '0 && !mem_req_valid) else $error("bad failure");
    cond_success_a: assert property (
        mem_ack && mem_req_valid && cond |=> wb_valid && wb.value == dw_store_pkg::SUCCESS_VALUE)
        else $error("bad success");
    fault_no_write_a: assert property (
        xlate_rsp.valid && bad |=> (!mem_req_valid && !wb_valid) [*2]) else $error("fault wrote");
    mem_hold_a: assert property (
        mem_req_valid && !mem_ack |=> mem_req_valid && $stable(mem_req)) else $error("store moved");
    flag_set_a: assert property (
        linked_double_load.valid |=> link_flag) else $error("flag not set");
    flag_exc_a: assert property (
        (exc_taken || exception_return_op) && !linked_double_load.valid |=> !link_flag)
        else $error("flag kept after exception");
    flag_snoop_a: assert property (
        coherent_store.valid && !linked_double_load.valid
        && (coherent_store.paddr >> dw_store_pkg::BLOCK_LSB) == blk |=> !link_flag)
        else $error("flag kept after snoop");
    cover property (mem_ack && cond);
    cover property (copro_req_valid);
    cover property (done && exc == dw_store_pkg::EXC_ADDR_ERROR);
endmodule

// File: testbench/mem_side_model.sv
// Translation, memory and coprocessor responder facing the store unit
`timescale 1ns/1ns
module mem_side_model (
    input wire logic core_clk,
    input wire logic xlate_req_valid,
    input wire logic [63:0] xlate_vaddr,
    input wire logic mem_req_valid,
    input wire logic copro_req_valid,
    input wire dw_store_pkg::copro_req_t copro_req,
    input wire logic [2:0] fault,
    input wire logic [3:0] lag,
    output dw_store_pkg::xlate_rsp_t xlate_rsp,
    output logic mem_ack,
    output logic copro_rsp_valid,
    output logic [63:0] copro_store_data
);
    initial begin
        xlate_rsp = '0;
        mem_ack = 1'b0;
        copro_rsp_valid = 1'b0;
        copro_store_data = '0;
    end
    ////////////////////////////////////////
    // Identity translation; idle fields inverted so stale values never pass
    always begin
        @(posedge core_clk);
        if (xlate_req_valid) begin
            repeat (lag) @(posedge core_clk);
            #1 xlate_rsp = {1'b1, xlate_vaddr[39:0], fault};
            @(posedge core_clk);
            #1 xlate_rsp = {1'b0, ~xlate_rsp[42:0]};
        end
    end
    always begin
        @(posedge core_clk);
        if (mem_req_valid) begin
            repeat (lag) @(posedge core_clk);
            #1 mem_ack = 1'b1;
            @(posedge core_clk);
            #1 mem_ack = 1'b0;
        end
    end
    // Data pattern names unit and register, so a wrong fetch shows
    always begin
        @(posedge core_clk);
        if (copro_req_valid) begin
            repeat (lag) @(posedge core_clk);
            #1 copro_store_data = {copro_req.unit, copro_req.src, 57'h1ABCDEF};
            copro_rsp_valid = 1'b1;
            @(posedge core_clk);
            #1 copro_rsp_valid = 1'b0;
            copro_store_data = ~copro_store_data;
        end
    end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the doubleword store unit
`timescale 1ns/1ns
module testbench;
    logic core_clk = 1'b0, resetn = 1'b0, issue_valid = 1'b0, enable64 = 1'b1;
    logic exc_taken = 1'b0, exception_return_op = 1'b0, lf = 1'b0, w;
    logic [3:0] copro_usable = 4'h6, lag = 4'h0;
    logic [2:0] fault = 3'h0;
    logic [63:0] seed = 64'h152, b, xlate_vaddr, copro_store_data;
    logic [33:0] blk;
    logic issue_ready, copro_req_valid, copro_rsp_valid, xlate_req_valid;
    logic mem_req_valid, mem_ack, wb_valid, done, link_flag;
    dw_store_pkg::issue_t issue = '0;
    dw_store_pkg::addr_evt_t linked_double_load = '0, coherent_store = '0;
    dw_store_pkg::copro_req_t copro_req;
    dw_store_pkg::xlate_rsp_t xlate_rsp;
    dw_store_pkg::mem_req_t mem_req, mq[$];
    dw_store_pkg::wb_t wb, wq[$];
    dw_store_pkg::exc_t exc;
    int n_fail = 0, n_checks = 0, k;
    int kinds[5] = '{1, 1, 2, 3, 0};
    localparam logic [5:0] P = dw_store_pkg::OPC_PLAIN_STORE;
    localparam logic [5:0] C = dw_store_pkg::OPC_COND_STORE;
    dw_store_unit dut (
        .core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
        .issue_ready(issue_ready), .enable64(enable64), .copro_usable(copro_usable),
        .linked_double_load(linked_double_load), .coherent_store(coherent_store),
        .exc_taken(exc_taken), .exception_return_op(exception_return_op),
        .copro_req_valid(copro_req_valid), .copro_req(copro_req),
        .copro_rsp_valid(copro_rsp_valid), .copro_store_data(copro_store_data),
        .xlate_req_valid(xlate_req_valid), .xlate_vaddr(xlate_vaddr), .xlate_rsp(xlate_rsp),
        .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_ack(mem_ack),
        .wb_valid(wb_valid), .wb(wb), .done(done), .exc(exc), .link_flag(link_flag)
    );
    mem_side_model mem_i (
        .core_clk(core_clk), .xlate_req_valid(xlate_req_valid), .xlate_vaddr(xlate_vaddr),
        .mem_req_valid(mem_req_valid), .copro_req_valid(copro_req_valid), .copro_req(copro_req),
        .fault(fault), .lag(lag), .xlate_rsp(xlate_rsp), .mem_ack(mem_ack),
        .copro_rsp_valid(copro_rsp_valid), .copro_store_data(copro_store_data)
    );
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (mem_req_valid === 1'b1 && mem_ack === 1'b1) mq.push_back(mem_req);
        if (wb_valid === 1'b1) wq.push_back(wb);
    end
    ////////////////////////////////////////
    function logic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction
    task complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [103:0] got, input logic [103:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tick();
        @(posedge core_clk);
        #1;
    endtask
    task stall();
        chk(1'b0, 1'b1);
        complete_run();
    endtask
    // Event pulse plus model of the link flag
    task automatic ev(input int kind, input logic [39:0] pa);
        linked_double_load = {kind == 0, pa};
        coherent_store = {kind == 1, pa};
        exc_taken = kind == 2;
        exception_return_op = kind == 3;
        if (kind == 0) begin
            lf = 1'b1;
            blk = pa[39:6];
        end else if (kind > 1 || pa[39:6] == blk) begin
            lf = 1'b0;
        end
        tick();
        linked_double_load = {1'b0, ~pa};
        coherent_store = {1'b0, ~pa};
        exc_taken = 1'b0;
        exception_return_op = 1'b0;
        tick();
        chk(link_flag, lf);
    endtask
    // Issue one store; base field 3, source field 9
    task automatic run(input logic [5:0] op, input logic [63:0] base, input logic [15:0] ofs,
            input logic [2:0] flt);
        logic [63:0] ea, src, d;
        int e, i;
        ea = base + {{48{ofs[15]}}, ofs};
        src = rnd();
        d = (op[1] ^ op[0]) ? {op[1:0], 5'h9, 57'h1ABCDEF} : src;
        e = (!enable64 || op[5:2] != 4'hF) ? 5 : ((op[1] ^ op[0]) && !copro_usable[op[1:0]]) ? 6 :
            ea[2:0] != 3'h0 ? 4 : flt[2] ? 1 : flt[1] ? 2 : flt[0] ? 3 : 0;
        fault = flt;
        lag = {2'h0, src[1:0]};
        issue = {op, 5'h3, 5'h9, ofs, base, src};
        for (i = 0; issue_ready !== 1'b1; i++) begin
            if (i > 40) stall();
            tick();
        end
        issue_valid = 1'b1;
        tick();
        issue_valid = 1'b0;
        for (i = 0; done !== 1'b1; i++) begin
            if (i > 40) stall();
            tick();
        end
        chk(exc, e);
        w = e == 0 && (op != C || lf);
        chk(mq.size(), w);
        if (w) chk(mq.pop_front(), {ea[39:0], d});
        if (e == 0 && op == C) begin
            chk(wq.size(), 1);
            chk(wq.pop_front(), {5'h9, 63'h0, lf});
            lf = 1'b0;
        end
        chk(wq.size(), 0);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1 resetn = 1'b1;
        for (k = 0; k < 8; k++) begin
            b = rnd();
            b[2:0] = 3'h0;
            run(P, b, {b[15:3], 3'h0}, 3'h0);
        end
        for (k = 1; k < 8; k++) begin
            run(P, 64'h1000 + k, 16'h0, 3'h0);
            run(C, 64'h2000 + k, 16'h0, 3'h0);
            run(6'h3D, 64'h3000 + k, 16'h0, 3'h0);
        end
        for (k = 0; k < 3; k++) run(P, 64'h4000, 16'h8, 3'h4 >> k);
        ev(0, 40'h4008);
        run(C, 64'h4000, 16'h8, 3'h0);
        run(C, 64'h4000, 16'h8, 3'h0);
        for (k = 0; k < 5; k++) begin
            ev(0, 40'h4008);
            ev(kinds[k], k == 1 ? 40'h4040 : 40'h4030);
            run(C, 64'h4010, 16'hFFF8, 3'h0);
        end
        run(6'h3D, 64'h5000, 16'h10, 3'h0);
        run(6'h3E, 64'h5000, 16'hFFF0, 3'h0);
        copro_usable = 4'h2;
        run(6'h3E, 64'h5000, 16'h10, 3'h0);
        run(6'h3B, 64'h5000, 16'h0, 3'h0);
        enable64 = 1'b0;
        run(P, 64'h5000, 16'h0, 3'h0);
        complete_run();
    end
endmodule
bind dw_store_unit dw_store_checker chk_i (
    .core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
    .issue_ready(issue_ready), .enable64(enable64), .copro_usable(copro_usable),
    .linked_double_load(linked_double_load), .coherent_store(coherent_store),
    .exc_taken(exc_taken), .exception_return_op(exception_return_op),
    .copro_req_valid(copro_req_valid), .copro_req(copro_req),
    .xlate_req_valid(xlate_req_valid), .xlate_vaddr(xlate_vaddr), .xlate_rsp(xlate_rsp),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_ack(mem_ack),
    .wb_valid(wb_valid), .wb(wb), .done(done), .exc(exc), .link_flag(link_flag)
);
